// ---- spsm_defines.svh ----
// Constants for the status pin source selector.
// Notes on behaviour
// - Four-bit source select in bits 7:4, reset 0x5, loaded from storage at start.
// - Code 0x0 shows primary reference loss of signal, 0x1 the secondary one.
// - Code 0x2 shows loop one loss of lock, 0x5 loop two.
// - Codes 0x3/0x6 show halved reference divider clock, only when not bypassed.
// - Codes 0x4/0x7 show feedback divider clock of loop one/two halved.
// - Codes 0xB/0xC show halved pre-divider clock, only when not bypassed.
// - Codes 0x8/0x9 show calibration active per loop; 0xD storage activity.
// - Code 0xA shows interrupt indication derived from interrupt flag bits.
// - Codes 0xE/0xF show automatic switch back to primary for each loop.
// - Polarity bit, reset 1, stored; set gives active high, clear active low.
// - Active test configuration overrides select and polarity on the pin.
`ifndef SPSM_DEFINES_SVH
`define SPSM_DEFINES_SVH
`define SPSM_CTRL_IDX     10'h01b
`define SPSM_CTRL_OFF     {`SPSM_CTRL_IDX, 2'b00}
`define SPSM_STAT_OFF     12'h070
`define SPSM_MASK_OFF     12'h074
`define SPSM_SEL_MSB      7
`define SPSM_SEL_LSB      4
`define SPSM_POL_BIT      3
`define SPSM_SEL_RESET    4'h5
`define SPSM_POL_RESET    1'b1
`define SPSM_NUM_TOGGLE   6
`define SPSM_NUM_EVENTS   2
`endif

// ---- spsm_pkg.sv ----
// Types for the status pin source selector.
package spsm_pkg;
   typedef enum logic [3:0] {
      SPSM_LOS_PRI  = 4'h0,
      SPSM_LOS_SEC  = 4'h1,
      SPSM_LOL_1    = 4'h2,
      SPSM_REF_1    = 4'h3,
      SPSM_FB_1     = 4'h4,
      SPSM_LOL_2    = 4'h5,
      SPSM_REF_2    = 4'h6,
      SPSM_FB_2     = 4'h7,
      SPSM_CAL_1    = 4'h8,
      SPSM_CAL_2    = 4'h9,
      SPSM_INTERRUPT_INDICATION     = 4'ha,
      SPSM_PRE_1    = 4'hb,
      SPSM_PRE_2    = 4'hc,
      SPSM_NVM      = 4'hd,
      SPSM_SWB_1    = 4'he,
      SPSM_SWB_2    = 4'hf
   } spsm_code_t;
endpackage

// ---- spsm_halver.sv ----
// Toggle flip-flop halving one divider output clock.
`timescale 1ns/1ps
module spsm_halver (
   input  wire logic div_clk,   // Divider output used as clock.
   input  wire logic presetn,   // Asynchronous reset, active low.
   output logic      half_out   // Divider clock divided by two.
);
   always_ff @(posedge div_clk or negedge presetn)
   begin
      if (!presetn)
         half_out <= 1'b0;
      else
         half_out <= ~half_out;
   end
endmodule // spsm_halver

// ---- spsm_status_mux.sv ----
// Status pin source selector with its APB register slave.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "spsm_defines.svh"
module spsm_status_mux
   import spsm_pkg::*;
(
   input  wire logic        pclk,          // Bus clock, 125 MHz.
   input  wire logic        presetn,       // Asynchronous reset, active low.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB access phase.
   input  wire logic        pwrite,        // APB write.
   input  wire logic [11:0] paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   output logic      [31:0] prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error, unmapped address.
   input  wire logic [3:0]  nvm_sel,       // Stored select from storage.
   input  wire logic        nvm_pol,       // Stored polarity from storage.
   input  wire logic        nvm_load,      // Start-up load strobe.
   input  wire logic        los_pri,       // Primary reference loss.
   input  wire logic        los_sec,       // Secondary reference loss.
   input  wire logic [1:0]  loss_of_lock,  // Loss of lock per loop.
   input  wire logic [1:0]  cal_active,    // Calibration active per loop.
   input  wire logic        int_flags_any, // Interrupt flag summary.
   input  wire logic        nvm_busy,      // Storage activity.
   input  wire logic [1:0]  switch_back,   // Switch-back per loop.
   input  wire logic [1:0]  ref_div_clk,   // Reference divider clocks.
   input  wire logic [1:0]  fb_div_clk,    // Feedback divider clocks.
   input  wire logic [1:0]  pre_div_clk,   // Pre-divider clocks.
   input  wire logic [1:0]  ref_bypass,    // Reference divider bypassed.
   input  wire logic [1:0]  pre_bypass,    // Pre-divider bypassed.
   input  wire logic        test_en,       // Test configuration active.
   input  wire logic        test_value,    // Test level for the pin.
   output logic             first_status_pin, // Status output pin.
   output logic             irq            // Interrupt, active high level.
);
   localparam int NT = `SPSM_NUM_TOGGLE;

   // Every check below runs on pclk and is quiet while reset is held.
   default clocking spsm_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [3:0]  status_source_select_reg;
   logic        status_polarity_bit_reg;
   logic [1:0]  evt_stat_reg;
   logic [1:0]  evt_mask_reg;
   logic [NT-1:0] div_clks;
   logic [NT-1:0] halves;
   logic [NT-1:0] sync1_reg;
   logic [NT-1:0] sync2_reg;
   logic [12:0] asy_in;
   logic [12:0] s1_reg;
   logic [12:0] s2_reg;
   logic        raw_level;
   logic        pin_next;
   logic        load_d_reg;
   logic [1:0]  swb_d_reg;
   logic [1:0]  evt_set;
   logic        wr_en;
   logic        rd_en;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_mask;

   // Divider order: ref1, ref2, fb1, fb2, pre1, pre2.
   assign div_clks = {pre_div_clk, fb_div_clk, ref_div_clk};

   genvar g;
   generate
      for (g = 0; g < NT; g++)
      begin : g_half
         spsm_halver u_half (
            .div_clk  (div_clks[g]),
            .presetn  (presetn),
            .half_out (halves[g])
         );
      end
   endgenerate

   // The halved clocks are unrelated to pclk, so they are synchronised too.
   // Their frequency must stay well below 62 MHz to survive this sampling.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= halves;
         sync2_reg <= sync1_reg;
      end
   end

   assign asy_in = {test_value, test_en, nvm_load, nvm_pol, nvm_busy,
                    int_flags_any, switch_back, cal_active, loss_of_lock,
                    los_pri};
   // Bit 0 above carries los_pri; los_sec synchronised separately below.
   logic s1_sec_reg;
   logic s2_sec_reg;
   logic [3:0] s1_nsel_reg;
   logic [3:0] s2_nsel_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_reg      <= '0;
         s2_reg      <= '0;
         s1_sec_reg  <= 1'b0;
         s2_sec_reg  <= 1'b0;
         s1_nsel_reg <= 4'h0;
         s2_nsel_reg <= 4'h0;
      end
      else
      begin
         s1_reg      <= asy_in;
         s2_reg      <= s1_reg;
         s1_sec_reg  <= los_sec;
         s2_sec_reg  <= s1_sec_reg;
         s1_nsel_reg <= nvm_sel;
         s2_nsel_reg <= s1_nsel_reg;
      end
   end

   logic       sy_los_pri;
   logic       sy_los_sec;
   logic [1:0] sy_lol;
   logic [1:0] sy_cal;
   logic [1:0] sy_swb;
   logic       sy_int;
   logic       sy_nvm;
   logic       sy_npol;
   logic       sy_load;
   logic       sy_test_en;
   logic       sy_test_val;
   assign sy_los_pri  = s2_reg[0];
   assign sy_lol      = s2_reg[2:1];
   assign sy_cal      = s2_reg[4:3];
   assign sy_swb      = s2_reg[6:5];
   assign sy_int      = s2_reg[7];
   assign sy_nvm      = s2_reg[8];
   assign sy_npol     = s2_reg[9];
   assign sy_load     = s2_reg[10];
   assign sy_test_en  = s2_reg[11];
   assign sy_test_val = s2_reg[12];
   assign sy_los_sec  = s2_sec_reg;

   // APB decode; every access completes with no wait state.
   assign hit_ctrl = (paddr == `SPSM_CTRL_OFF);
   assign hit_stat = (paddr == `SPSM_STAT_OFF);
   assign hit_mask = (paddr == `SPSM_MASK_OFF);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !(hit_ctrl || hit_stat || hit_mask);
   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && !penable && !pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         load_d_reg <= 1'b0;
      else
         load_d_reg <= sy_load;
   end

   // Storage load on the rising edge of the load strobe; a bus write in the
   // same cycle loses, so the start-up image always lands intact.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_source_select_reg <= `SPSM_SEL_RESET;
         status_polarity_bit_reg  <= `SPSM_POL_RESET;
      end
      else if (sy_load && !load_d_reg)
      begin
         status_source_select_reg <= s2_nsel_reg;
         status_polarity_bit_reg  <= sy_npol;
      end
      else if (wr_en && hit_ctrl)
      begin
         status_source_select_reg <= pwdata[`SPSM_SEL_MSB:`SPSM_SEL_LSB];
         status_polarity_bit_reg  <= pwdata[`SPSM_POL_BIT];
      end
   end

   // Events: switch-back rising edges, sticky until written with a one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         swb_d_reg <= 2'h0;
      else
         swb_d_reg <= sy_swb;
   end
   assign evt_set = sy_swb & ~swb_d_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_stat_reg <= 2'h0;
      else if (wr_en && hit_stat)
         evt_stat_reg <= (evt_stat_reg & ~pwdata[1:0]) | evt_set;
      else
         evt_stat_reg <= evt_stat_reg | evt_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_mask_reg <= 2'h0;
      else if (wr_en && hit_mask)
         evt_mask_reg <= pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(evt_stat_reg & evt_mask_reg);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         prdata <= 32'h0000_0000;
         if (hit_ctrl)
            prdata[7:0] <= {status_source_select_reg,
                            status_polarity_bit_reg, 3'h0};
         else if (hit_stat)
            prdata[1:0] <= evt_stat_reg;
         else if (hit_mask)
            prdata[1:0] <= evt_mask_reg;
      end
   end

   // A bypassed divider shows low rather than a stale toggle state.
   always_comb
   begin
      raw_level = 1'b0;
      unique case (spsm_code_t'(status_source_select_reg))
         SPSM_LOS_PRI: raw_level = sy_los_pri;
         SPSM_LOS_SEC: raw_level = sy_los_sec;
         SPSM_LOL_1:   raw_level = sy_lol[0];
         SPSM_LOL_2:   raw_level = sy_lol[1];
         SPSM_REF_1:   raw_level = sync2_reg[0] & ~ref_bypass[0];
         SPSM_REF_2:   raw_level = sync2_reg[1] & ~ref_bypass[1];
         SPSM_FB_1:    raw_level = sync2_reg[2];
         SPSM_FB_2:    raw_level = sync2_reg[3];
         SPSM_PRE_1:   raw_level = sync2_reg[4] & ~pre_bypass[0];
         SPSM_PRE_2:   raw_level = sync2_reg[5] & ~pre_bypass[1];
         SPSM_CAL_1:   raw_level = sy_cal[0];
         SPSM_CAL_2:   raw_level = sy_cal[1];
         SPSM_NVM:     raw_level = sy_nvm;
         SPSM_INTERRUPT_INDICATION:    raw_level = sy_int;
         SPSM_SWB_1:   raw_level = sy_swb[0];
         SPSM_SWB_2:   raw_level = sy_swb[1];
      endcase
   end

   always_comb
   begin
      if (sy_test_en)
         pin_next = sy_test_val;
      else
         pin_next = raw_level ^ ~status_polarity_bit_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         first_status_pin <= 1'b0;
      else
         first_status_pin <= pin_next;
   end

   chk_pol_follow: assert property (!sy_test_en ##1 1'b1 |->
      first_status_pin ==
         ($past(raw_level) ^ ~$past(status_polarity_bit_reg)))
      else $error("status pin does not follow source and polarity");

   chk_test_wins: assert property (sy_test_en |=>
      first_status_pin == $past(sy_test_val))
      else $error("test level not on status pin");

   chk_lol_two: assert property (
      (status_source_select_reg == 4'h5 && !sy_test_en) |=>
         first_status_pin ==
            ($past(sy_lol[1]) ^ ~$past(status_polarity_bit_reg)))
      else $error("loop two loss of lock not routed");

   chk_los_pri: assert property (
      (status_source_select_reg == 4'h0 && !sy_test_en) |=>
         first_status_pin ==
            ($past(sy_los_pri) ^ ~$past(status_polarity_bit_reg)))
      else $error("primary loss of signal not routed");

   chk_ref_bypass: assert property (
      (status_source_select_reg == 4'h3 && ref_bypass[0]) |->
         raw_level == 1'b0)
      else $error("bypassed reference divider reaches pin");

   chk_ref2_bypass: assert property (
      (status_source_select_reg == 4'h6 && ref_bypass[1]) |->
         raw_level == 1'b0)
      else $error("bypassed second reference divider reaches pin");

   chk_pre_bypass: assert property (
      (status_source_select_reg == 4'hc && pre_bypass[1]) |->
         raw_level == 1'b0)
      else $error("bypassed pre-divider reaches pin");

   chk_pre1_bypass: assert property (
      (status_source_select_reg == 4'hb && pre_bypass[0]) |->
         raw_level == 1'b0)
      else $error("bypassed first pre-divider reaches pin");

   chk_fb_route: assert property (
      (status_source_select_reg == 4'h4) |-> raw_level == sync2_reg[2])
      else $error("feedback divider clock not routed");

   chk_cal_route: assert property (
      (status_source_select_reg == 4'h8) |-> raw_level == sy_cal[0])
      else $error("calibration activity not routed");

   chk_swb_route: assert property (
      (status_source_select_reg == 4'he) |-> raw_level == sy_swb[0])
      else $error("switch back indication not routed");

   chk_rsvd_zero: assert property (
      (psel && penable && !pwrite && hit_ctrl) |-> prdata[2:0] == 3'h0)
      else $error("reserved bits read nonzero");

   chk_sel_write: assert property (
      (wr_en && hit_ctrl && !(sy_load && !load_d_reg)) |=>
         status_source_select_reg == $past(pwdata[7:4]))
      else $error("select write not stored");

   chk_load_wins: assert property (
      (sy_load && !load_d_reg) |=>
         (status_source_select_reg == $past(s2_nsel_reg) &&
          status_polarity_bit_reg == $past(sy_npol)))
      else $error("storage image not loaded");

   chk_interrupt_indication_route: assert property (
      (status_source_select_reg == 4'ha) |-> raw_level == sy_int)
      else $error("interrupt indication not routed");

   chk_evt_sticky: assert property (
      (evt_set != 2'h0) |=>
         (evt_stat_reg & $past(evt_set)) == $past(evt_set))
      else $error("event lost against a clear");

endmodule // spsm_status_mux

// ---- spsm_pin_monitor.sv ----
// Model of the external logic that watches the status pin.
`timescale 1ns/1ps
module spsm_pin_monitor (
   input  wire logic       pclk,  // Sampling clock.
   input  wire logic       pin,   // Status pin as seen on the board.
   input  wire logic       clr,   // Restarts the transition count.
   output logic      [7:0] edges  // Transitions seen since the restart.
);
   logic last_reg;
   // Counting transitions rather than timing them tolerates the sync delay.
   always_ff @(posedge pclk)
   begin
      last_reg <= pin;
      if (clr)
         edges <= 8'h00;
      else if (pin !== last_reg)
         edges <= edges + 8'h01;
   end
endmodule // spsm_pin_monitor

// ---- spsm_status_mux_test.sv ----
// Self-checking testbench for the status pin source selector.
`timescale 1ns/1ps
`include "spsm_defines.svh"
module spsm_status_mux_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  nvm_sel;
   logic        nvm_pol, nvm_load, los_pri, los_sec, int_flags_any, nvm_busy;
   logic [1:0]  loss_of_lock, cal_active, switch_back, ref_bypass, pre_bypass;
   logic [1:0]  ref_div_clk, fb_div_clk, pre_div_clk;
   logic        test_en, test_value, pin, irq, clr, byp;
   logic [7:0]  edges;
   logic [2:0]  dcnt = 3'h0;
   logic [3:0]  lvl [10] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hd,
                             4'he, 4'hf};
   logic [3:0]  dv [6] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hb, 4'hc};
   int          n_errors, samples_checked;

   spsm_status_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvm_sel(nvm_sel), .nvm_pol(nvm_pol), .nvm_load(nvm_load),
      .los_pri(los_pri), .los_sec(los_sec), .loss_of_lock(loss_of_lock),
      .cal_active(cal_active), .int_flags_any(int_flags_any),
      .nvm_busy(nvm_busy), .switch_back(switch_back),
      .ref_div_clk(ref_div_clk), .fb_div_clk(fb_div_clk),
      .pre_div_clk(pre_div_clk), .ref_bypass(ref_bypass),
      .pre_bypass(pre_bypass), .test_en(test_en), .test_value(test_value),
      .first_status_pin(pin), .irq(irq));
   spsm_pin_monitor mon_u (.pclk(pclk), .pin(pin), .clr(clr), .edges(edges));

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Divider clocks at an eighth of pclk keep the halved pin slow enough.
   always @(posedge pclk)
   begin
      dcnt <= dcnt + 3'h1;
      ref_div_clk <= {2{dcnt[2]}};
      fb_div_clk <= {2{dcnt[2]}};
      pre_div_clk <= {2{dcnt[2]}};
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_range(input int lo, input int hi, input logic [7:0] g);
      samples_checked++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         n_errors++;
         $display("MISMATCH pin edges expected %0d..%0d seen %0d", lo, hi, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
      begin
         n_errors++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic settle();
      repeat (6) @(posedge pclk);
   endtask

   // Reference model of the level sources, indexed by select code.
   function automatic logic src(input logic [3:0] c);
      case (c)
         4'h0: return los_pri;
         4'h1: return los_sec;
         4'h2: return loss_of_lock[0];
         4'h5: return loss_of_lock[1];
         4'h8: return cal_active[0];
         4'h9: return cal_active[1];
         4'ha: return int_flags_any;
         4'hd: return nvm_busy;
         4'he: return switch_back[0];
         default: return switch_back[1];
      endcase
   endfunction

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, nvm_sel, nvm_pol, nvm_load} = '0;
      {los_pri, los_sec, loss_of_lock, cal_active, int_flags_any} = '0;
      {nvm_busy, switch_back, ref_bypass, pre_bypass, test_en} = '0;
      test_value = 1'b0;
      presetn = 1'b0;
      clr = 1'b0;
      n_errors = 0;
      samples_checked = 0;
      void'($urandom(19055));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `SPSM_CTRL_OFF, 32'h0);
      check("ctrl reset", 32'h58, rd);
      apb(1'b1, `SPSM_CTRL_OFF, 32'hff);
      apb(1'b0, `SPSM_CTRL_OFF, 32'h0);
      check("ctrl reserved", 32'hf8, rd);
      apb(1'b0, 12'h078, 32'h0);
      check("unmapped err", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rd);
      $display("registers done");
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 10; i++)
         begin
            apb(1'b1, `SPSM_CTRL_OFF, {24'h0, lvl[i], p[0], 3'h0});
            repeat (2)
            begin
               {los_pri, los_sec, loss_of_lock, cal_active, int_flags_any,
                nvm_busy, switch_back} <= 10'($urandom);
               settle();
               check("pin level", {31'h0, src(lvl[i]) ^ !p[0]}, {31'h0, pin});
            end
         end
      $display("level sources done");
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 6; i++)
         begin
            ref_bypass <= {2{b[0]}};
            pre_bypass <= {2{b[0]}};
            apb(1'b1, `SPSM_CTRL_OFF, {24'h0, dv[i], 4'h8});
            settle();
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            repeat (64) @(posedge pclk);
            byp = b[0] && dv[i] != 4'h4 && dv[i] != 4'h7;
            if (byp)
               check_range(0, 0, edges);
            else
               check_range(6, 10, edges);
         end
      $display("divider sources done");
      test_en <= 1'b1;
      for (int j = 0; j < 4; j++)
      begin
         test_value <= 1'($urandom);
         apb(1'b1, `SPSM_CTRL_OFF, {24'h0, 4'h0, j[0], 3'h0});
         settle();
         check("pin override", {31'h0, test_value}, {31'h0, pin});
      end
      test_en <= 1'b0;
      $display("test override done");
      nvm_sel <= 4'($urandom);
      nvm_pol <= 1'($urandom);
      nvm_load <= 1'b1;
      settle();
      nvm_load <= 1'b0;
      apb(1'b0, `SPSM_CTRL_OFF, 32'h0);
      check("ctrl loaded", {24'h0, nvm_sel, nvm_pol, 3'h0}, rd);
      $display("storage load done");
      switch_back <= 2'b00;
      settle();
      apb(1'b1, `SPSM_STAT_OFF, 32'h3);
      apb(1'b1, `SPSM_MASK_OFF, 32'h0);
      switch_back <= 2'b01;
      settle();
      check("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, `SPSM_STAT_OFF, 32'h0);
      check("event status", 32'h1, rd);
      apb(1'b1, `SPSM_MASK_OFF, 32'h1);
      settle();
      check("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, `SPSM_STAT_OFF, 32'h1);
      settle();
      check("irq cleared", 32'h0, {31'h0, irq});
      $display("interrupts done");
      report_and_stop();
   end
endmodule // spsm_status_mux_test
